// ==== tb/tb_top.sv ====
// Self-checking bench for the timer channel: interval and width capture.
// Assumes the pulse source model drives the timer input pin.
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        pin;
  logic        irq;
  logic        run;
  logic [16:0] hi_len;
  logic [16:0] lo_len;
  logic [31:0] q;
  logic [31:0] q1;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          irq_cnt = 0;
  int          seed;
  int          b;
  int          h;

  tcic_top i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .timer_input_pin(pin), .channel_interrupt(irq));
  tcic_pulse_src i_src (.clk(clk), .run(run), .hi_len(hi_len), .lo_len(lo_len), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  function automatic logic [31:0] cnt16(input int v);
    return 32'(v % 65536);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) error_cnt++;
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(q, e);
  endtask

  task automatic wait_irq(input int target);
    int n;
    n = 0;
    while (irq_cnt < target && n < 70000) begin
      @(posedge clk);
      n++;
    end
    if (irq_cnt < target) error_cnt++;
  endtask

  task automatic run_interval(input int ies, input int cks);
    int half;
    int iv;
    half = 2 * (10 + ($random(seed) & 31));
    iv = (ies == 2) ? half : 2 * half;
    hi_len <= 17'(half);
    lo_len <= 17'(half);
    xfer(1'b1, tcic_pkg::OFS_MODE, 32'h105 | 32'(ies) << 6 | 32'(cks) << 15);
    b = irq_cnt;
    xfer(1'b1, tcic_pkg::OFS_TRIGGER, 32'h1);
    repeat (20) @(posedge clk);
    check(32'(irq_cnt), 32'(b + 1));
    run <= 1'b1;
    wait_irq(b + 4);
    rd_chk(tcic_pkg::OFS_CAPTURE, 32'(iv / (cks + 1) - 1));
    rd_chk(tcic_pkg::OFS_STATUS, 32'h0);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    b = irq_cnt;
    xfer(1'b1, tcic_pkg::OFS_TRIGGER, 32'h1);
    repeat (10) @(posedge clk);
    check(32'(irq_cnt), 32'(b + 1));
    xfer(1'b1, tcic_pkg::OFS_TRIGGER, 32'h2);
    rd_chk(tcic_pkg::OFS_ENABLE, 32'h0);
    xfer(1'b0, tcic_pkg::OFS_COUNTER, 32'h0);
    q1 = q;
    repeat (8) @(posedge clk);
    rd_chk(tcic_pkg::OFS_COUNTER, q1);
  endtask

  task automatic run_width(input logic [31:0] m, input int hl, input int ll, input int w);
    hi_len <= 17'(hl);
    lo_len <= 17'(ll);
    xfer(1'b1, tcic_pkg::OFS_MODE, m);
    b = irq_cnt;
    xfer(1'b1, tcic_pkg::OFS_TRIGGER, 32'h1);
    rd_chk(tcic_pkg::OFS_ENABLE, 32'h1);
    run <= 1'b1;
    wait_irq(b + 1);
    rd_chk(tcic_pkg::OFS_CAPTURE, cnt16(w - 1));
    rd_chk(tcic_pkg::OFS_COUNTER, cnt16(w));
    rd_chk(tcic_pkg::OFS_STATUS, 32'(w / 65536));
    xfer(1'b1, tcic_pkg::OFS_TRIGGER, 32'h2);
    run <= 1'b0;
    rd_chk(tcic_pkg::OFS_STATUS, 32'(w / 65536));
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    seed = 66;
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat = 32'h0;
    run = 1'b0;
    hi_len = 17'h10;
    lo_len = 17'h10;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b1, tcic_pkg::OFS_MODE, 32'h144);
    rd_chk(tcic_pkg::OFS_MODE, 32'h0);
    xfer(1'b1, tcic_pkg::OFS_UNIT_CTRL, 32'h1);
    xfer(1'b1, tcic_pkg::OFS_PRESCALER, 32'h10);
    rd_chk(tcic_pkg::OFS_PRESCALER, 32'h10);
    xfer(1'b1, tcic_pkg::OFS_OUTPUT_CTL, 32'h0);
    rd_chk(tcic_pkg::OFS_TRIGGER, 32'h0);
    rd_chk(8'h30, 32'h0);
    for (int k = 0; k < 6; k++) begin
      run_interval(k % 3, k / 3);
    end
    h = 20 + ($random(seed) & 63);
    run_width(32'h1cc, h, 80, h);
    h = 20 + ($random(seed) & 63);
    run_width(32'h18c, 80, h, h);
    run_width(32'h1cc, 65636, 80, 65636);
    xfer(1'b1, tcic_pkg::OFS_UNIT_CTRL, 32'h0);
    rd_chk(tcic_pkg::OFS_CAPTURE, 32'h0);
    rd_chk(tcic_pkg::OFS_STATUS, 32'h0);
    rd_chk(tcic_pkg::OFS_MODE, 32'h0);
    final_report();
  end

  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end
endmodule

// ==== tb/tcic_props.sv ====
// Checker for the timer channel top ports.
// Assumes it is bound into tcic_top; one clock domain, synchronous reset.
`timescale 1ns/1ps
module tcic_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pin and event
  input wire logic        timer_input_pin,
  input wire logic        channel_interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic rd;
  logic pwr;
  logic pwr_d;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd   = take && !wb_we_i;
  // Tracks the unit power bit so power-off behaviour can be judged.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr   <= 1'b0;
      pwr_d <= 1'b0;
    end else begin
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == tcic_pkg::OFS_UNIT_CTRL)
        pwr <= wb_dat_i[0];
      pwr_d <= pwr;
    end
  end
  a_ack_next:  assert property (take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
  a_rdat_hold: assert property (!rd |=> $stable(wb_dat_o)) else $error("read data moved");
  a_trig_zero: assert property (rd && wb_adr_i == tcic_pkg::OFS_TRIGGER |=> wb_dat_o == 32'h0)
    else $error("trigger bits stored");
  a_unmap_zero: assert property (rd && wb_adr_i > tcic_pkg::OFS_OUTPUT_CTL |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_ovf_one_bit: assert property (rd && wb_adr_i == tcic_pkg::OFS_STATUS |=> wb_dat_o[31:1] == 31'h0)
    else $error("status wider than one bit");
  a_cnt_width: assert property (rd && wb_adr_i == tcic_pkg::OFS_COUNTER |=> wb_dat_o[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  a_off_quiet: assert property (!pwr && !pwr_d |-> !channel_interrupt)
    else $error("interrupt while powered off");
  a_off_reads: assert property (!pwr && !pwr_d && rd && wb_adr_i == tcic_pkg::OFS_CAPTURE |=> wb_dat_o == 32'h0)
    else $error("capture not cleared when off");
endmodule

bind tcic_top tcic_props i_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_input_pin(timer_input_pin), .channel_interrupt(channel_interrupt));

// ==== tb/tcic_pulse_src.sv ====
// External pulse source for the timer input pin.
// Assumes lengths are in clk cycles; the pin rests low while not running.
`timescale 1ns/1ps
module tcic_pulse_src (
  // Clock
  input wire logic        clk,
  // Control
  input wire logic        run,
  input wire logic [16:0] hi_len,
  input wire logic [16:0] lo_len,
  // Pin
  output logic            pin
);
  logic [16:0] cnt;
  initial begin
    pin = 1'b0;
    cnt = 17'h0;
  end
  always @(posedge clk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt <= 17'h0;
    end else if (cnt + 17'h1 >= (pin ? hi_len : lo_len)) begin
      pin <= !pin;
      cnt <= 17'h0;
    end else begin
      cnt <= cnt + 17'h1;
    end
  end
endmodule

// ==== verilog/tcic_chan_if.sv ====
// Carries operating clock ticks and sampled input edges inside the channel.
// Assumes all parties run on the same clk.
`timescale 1ns/1ps
interface tcic_chan_if;
  logic pwr;
  logic tick_a;
  logic tick_b;
  logic clk_sel;
  logic rise;
  logic fall;

  modport presc (input pwr, output tick_a, output tick_b);
  modport edge_det (input pwr, input tick_a, input tick_b, input clk_sel,
                    output rise, output fall);
  modport core (output pwr, output clk_sel, input tick_a, input tick_b,
                input rise, input fall);
endinterface

// ==== verilog/tcic_edge_detect.sv ====
// Synchronises the timer input pin, filters it and samples it on the
// selected operating clock tick, giving one-cycle rise and fall pulses.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module tcic_edge_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin
  input  wire logic timer_input_pin,
  // Edges
  tcic_chan_if.edge_det chan
);

  typedef struct packed {
    logic [2:0] sync;
    logic       filt;
    logic       samp;
    logic       rise;
    logic       fall;
  } tcic_edge_s;

  tcic_edge_s s;
  tcic_edge_s next_s;
  logic       tick;

  always_comb begin
    next_s = s;
    tick = chan.clk_sel ? chan.tick_b : chan.tick_a;
    next_s.sync = {s.sync[1:0], timer_input_pin};
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    if (s.sync[1] == s.sync[2]) begin
      next_s.filt = s.sync[2];
    end
    // R8 sampled on tick
    if (tick) begin
      next_s.samp = s.filt;
      next_s.rise = s.filt & ~s.samp;
      next_s.fall = ~s.filt & s.samp;
    end
    if (!chan.pwr) begin
      next_s.samp = s.filt;
      next_s.rise = 1'b0;
      next_s.fall = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign chan.rise = s.rise;
  assign chan.fall = s.fall;

endmodule

// ==== verilog/tcic_pkg.sv ====
// Constants for the single timer channel with interval and width capture.
// Assumes a 32-bit classic Wishbone bus with byte addresses, one word a register.
package tcic_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_UNIT_CTRL  = 8'h00;
  localparam logic [7:0] OFS_PRESCALER  = 8'h04;
  localparam logic [7:0] OFS_MODE       = 8'h08;
  localparam logic [7:0] OFS_TRIGGER    = 8'h0c;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_COUNTER    = 8'h14;
  localparam logic [7:0] OFS_CAPTURE    = 8'h18;
  localparam logic [7:0] OFS_ENABLE     = 8'h1c;
  localparam logic [7:0] OFS_OUTPUT_CTL = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int TRIG_START_BIT = 0;
  localparam int TRIG_STOP_BIT  = 1;
  localparam int MODE_MD0_BIT   = 0;
  localparam int MODE_OP_LSB    = 1;
  localparam int MODE_IES_LSB   = 6;
  localparam int MODE_STS_LSB   = 8;
  localparam int MODE_CKS_BIT   = 15;
  localparam int PRE_B_LSB      = 4;

  // ---------------------------------------------------------------------------
  // Encodings and values after reset
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  OP_INTERVAL   = 3'h2;
  localparam logic [2:0]  OP_WIDTH      = 3'h6;
  localparam logic [2:0]  STS_PIN_EDGE  = 3'h1;
  localparam logic [1:0]  IES_FALL      = 2'h0;
  localparam logic [1:0]  IES_RISE      = 2'h1;
  localparam logic [1:0]  IES_BOTH      = 2'h2;
  localparam logic [1:0]  IES_LOW_WIDTH = 2'h2;
  localparam logic [1:0]  IES_HIGH_WID  = 2'h3;
  localparam logic [15:0] RST_MODE      = 16'h0000;
  localparam logic [7:0]  RST_PRESCALER = 8'h00;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [15:0] COUNT_FULL    = 16'hffff;
  localparam logic [3:0]  RST_OUTPUT    = 4'h0;

endpackage

// ==== verilog/tcic_prescaler.sv ====
// Makes the two shared operating clock ticks as one-cycle enables of clk.
// Assumes the unit power bit stops and clears it.
`timescale 1ns/1ps
module tcic_prescaler (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Divider settings, exponent of two per clock
  input  wire logic [3:0] div_a,
  input  wire logic [3:0] div_b,
  // Ticks
  tcic_chan_if.presc      chan
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        ta;
    logic        tb;
  } tcic_presc_s;

  tcic_presc_s s;
  tcic_presc_s next_s;

  function automatic logic tick_of(input logic [15:0] cnt, input logic [3:0] n);
    logic [15:0] mask;
    mask = 16'((17'h1 << n) - 17'h1);
    return (cnt & mask) == mask;
  endfunction

  always_comb begin
    next_s = s;
    next_s.cnt = s.cnt + 16'h0001;
    next_s.ta = tick_of(s.cnt, div_a);
    next_s.tb = tick_of(s.cnt, div_b);
    if (!chan.pwr) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign chan.tick_a = s.ta;
  assign chan.tick_b = s.tb;

endmodule

// ==== verilog/tcic_top.sv ====
// Timer channel measuring pulse interval or high/low width of an input pin.
// Assumes a classic Wishbone master on clk and an asynchronous input pin.
//
// Operation
// R1 - Interval start: counter counts up from zero.
// R2 - Interval edge: capture, clear counter, interrupt.
// R3 - Overflow flag reflects wrap during period.
// R4 - Overflow is one sticky bit per period.
// R5 - Width is period times overflow-extended capture plus one.
// R6 - Interval needs start trigger select 001B.
// R7 - Software start while running captures too.
// R8 - Pin sampled with selected operating clock.
// R9 - First count clock clears counter, optional interrupt.
// R10 - Stop clears enable, holds counter and flag.
// R11 - Start and stop bits self clear.
// R12 - Only edge bits change while running; the code accepts writes to all mode bits while running.
// R13 - Width start arms wait for start edge.
// R14 - Start edge clears counter, counts up.
// R15 - Capture edge stores, interrupts, stops at value+1.
// R16 - 10B low width, 11B high width.
// R17 - No width start while enabled.
// R18 - Power off stops clock, blocks writes.
// R19 - Power off resets unit and channel.
// R20 - Prescaler sets two clocks, select picks one.
// R21 - Output kept disabled, zero, toggle mode.
// R22 - Sixteen-bit counter wraps, wrap counts as overflow.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module tcic_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Timer pin and event
  input  wire logic        timer_input_pin,
  output logic             channel_interrupt
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_RUN,
    ST_WAIT_START,
    ST_WIDTH_RUN
  } tcic_state_e;

  typedef struct packed {
    logic        pwr;
    logic [7:0]  presc;
    logic [15:0] mode;
    logic [3:0]  outctl;
    logic        en;
    tcic_state_e st;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic        ovf;
    logic        ovf_pend;
    logic        irq;
    logic        tick_d;
    logic        ack;
    logic [31:0] dat;
  } tcic_core_s;

  tcic_core_s  s;
  tcic_core_s  next_s;
  tcic_chan_if chan ();

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] inc(input logic [15:0] v);
    return v + 16'h0001;
  endfunction

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  tcic_prescaler u_presc (
    .clk   (clk),
    .rst_n (rst_n),
    .div_a (s.presc[3:0]),
    .div_b (s.presc[tcic_pkg::PRE_B_LSB +: 4]),
    .chan  (chan)
  );

  tcic_edge_detect u_edge (
    .clk             (clk),
    .rst_n           (rst_n),
    .timer_input_pin (timer_input_pin),
    .chan            (chan)
  );

  assign chan.pwr = s.pwr;
  // R20 clock select
  assign chan.clk_sel = s.mode[tcic_pkg::MODE_CKS_BIT];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        start_wr;
  logic        stop_wr;
  logic        tick;
  logic [2:0]  op;
  logic [1:0]  ies;
  logic        edge_ok;
  logic        pin_cap;
  logic        w_start;
  logic        w_cap;
  logic [31:0] rd;
  logic [31:0] mrg;

  always_comb begin
    next_s = s;
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = req & wb_we_i;
    mrg = 32'h0;
    rd = 32'h0;
    start_wr = 1'b0;
    stop_wr = 1'b0;
    // The edge pulses leave the detector one cycle after the tick that sampled
    // the pin, so counting runs on the delayed tick to keep both in one phase.
    next_s.tick_d = s.mode[tcic_pkg::MODE_CKS_BIT] ? chan.tick_b : chan.tick_a;
    tick = s.tick_d;
    op = s.mode[tcic_pkg::MODE_OP_LSB +: 3];
    ies = s.mode[tcic_pkg::MODE_IES_LSB +: 2];
    // R6 edges need start trigger select 001B
    edge_ok = s.mode[tcic_pkg::MODE_STS_LSB +: 3] == tcic_pkg::STS_PIN_EDGE;
    unique case (ies)
      tcic_pkg::IES_FALL: pin_cap = chan.fall;
      tcic_pkg::IES_RISE: pin_cap = chan.rise;
      tcic_pkg::IES_BOTH: pin_cap = chan.rise | chan.fall;
      default:            pin_cap = 1'b0;
    endcase
    pin_cap = pin_cap & edge_ok;
    // R16 width edge pairing
    w_start = ies[0] ? chan.rise : chan.fall;
    w_cap = ies[0] ? chan.fall : chan.rise;
    next_s.irq = 1'b0;

    // Bus access: one-cycle answer, ack drops the cycle after.
    next_s.ack = req;
    if (req) begin
      mrg = merge(32'h0, wb_dat_i, wb_sel_i);
      unique case (wb_adr_i)
        tcic_pkg::OFS_UNIT_CTRL:  rd = {31'h0, s.pwr};
        tcic_pkg::OFS_PRESCALER:  rd = {24'h0, s.presc};
        tcic_pkg::OFS_MODE:       rd = {16'h0, s.mode};
        tcic_pkg::OFS_STATUS:     rd = {31'h0, s.ovf};
        tcic_pkg::OFS_COUNTER:    rd = {16'h0, s.cnt};
        tcic_pkg::OFS_CAPTURE:    rd = {16'h0, s.cap};
        tcic_pkg::OFS_ENABLE:     rd = {31'h0, s.en};
        tcic_pkg::OFS_OUTPUT_CTL: rd = {28'h0, s.outctl};
        default:                  rd = 32'h0;
      endcase
      // R11 trigger bits read as zero
      next_s.dat = wb_we_i ? s.dat : rd;
    end
    if (wr && wb_adr_i == tcic_pkg::OFS_UNIT_CTRL && wb_sel_i[0]) begin
      next_s.pwr = wb_dat_i[0];
    end
    // R18 writes ignored while powered off
    if (wr && s.pwr) begin
      unique case (wb_adr_i)
        tcic_pkg::OFS_PRESCALER: begin
          next_s.presc = 8'(merge({24'h0, s.presc}, wb_dat_i, wb_sel_i));
        end
        tcic_pkg::OFS_MODE: begin
          next_s.mode = 16'(merge({16'h0, s.mode}, wb_dat_i, wb_sel_i));
        end
        tcic_pkg::OFS_OUTPUT_CTL: begin
          next_s.outctl = 4'(merge({28'h0, s.outctl}, wb_dat_i, wb_sel_i));
        end
        tcic_pkg::OFS_TRIGGER: begin
          // R11 pulses only
          start_wr = mrg[tcic_pkg::TRIG_START_BIT];
          stop_wr = mrg[tcic_pkg::TRIG_STOP_BIT];
        end
        default: begin
        end
      endcase
    end

    // Channel sequencing.
    unique case (s.st)
      ST_IDLE: begin
        if (start_wr && op == tcic_pkg::OP_INTERVAL) begin
          next_s.en = 1'b1;
          next_s.st = ST_ARM;
        end else if (start_wr && op == tcic_pkg::OP_WIDTH) begin
          // R13 wait for start edge
          next_s.en = 1'b1;
          next_s.st = ST_WAIT_START;
        end
      end
      ST_ARM: begin
        // R9 clear at first count clock
        if (tick) begin
          next_s.cnt = tcic_pkg::RST_COUNT;
          next_s.ovf_pend = 1'b0;
          next_s.irq = s.mode[tcic_pkg::MODE_MD0_BIT];
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        // R7 software capture
        if (pin_cap || start_wr) begin
          // R2 capture, clear, interrupt
          next_s.cap = s.cnt;
          next_s.cnt = tcic_pkg::RST_COUNT;
          // R3 flag per period
          next_s.ovf = s.ovf_pend;
          next_s.ovf_pend = 1'b0;
          next_s.irq = 1'b1;
        end else if (tick) begin
          // R1 count up
          next_s.cnt = inc(s.cnt);
          // R22 wrap is overflow
          // R4 single sticky bit
          if (s.cnt == tcic_pkg::COUNT_FULL) begin
            next_s.ovf_pend = 1'b1;
          end
        end
      end
      ST_WAIT_START: begin
        // R14 start edge clears counter
        if (w_start) begin
          next_s.cnt = tcic_pkg::RST_COUNT;
          next_s.ovf_pend = 1'b0;
          next_s.st = ST_WIDTH_RUN;
        end
      end
      ST_WIDTH_RUN: begin
        if (w_cap) begin
          // R15 capture, stop at value+1
          next_s.cap = s.cnt;
          next_s.cnt = inc(s.cnt);
          next_s.ovf = s.ovf_pend;
          next_s.irq = 1'b1;
          next_s.st = ST_WAIT_START;
        end else if (tick) begin
          next_s.cnt = inc(s.cnt);
          if (s.cnt == tcic_pkg::COUNT_FULL) begin
            next_s.ovf_pend = 1'b1;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // R10 stop holds counter and flag
    if (stop_wr) begin
      next_s.en = 1'b0;
      next_s.st = ST_IDLE;
    end

    // R19 power off resets the unit
    if (!s.pwr) begin
      next_s.presc = tcic_pkg::RST_PRESCALER;
      next_s.mode = tcic_pkg::RST_MODE;
      next_s.outctl = tcic_pkg::RST_OUTPUT;
      next_s.en = 1'b0;
      next_s.st = ST_IDLE;
      next_s.cnt = tcic_pkg::RST_COUNT;
      next_s.cap = tcic_pkg::RST_COUNT;
      next_s.ovf = 1'b0;
      next_s.ovf_pend = 1'b0;
      next_s.irq = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{pwr: 1'b0, presc: tcic_pkg::RST_PRESCALER, mode: tcic_pkg::RST_MODE,
             outctl: tcic_pkg::RST_OUTPUT, en: 1'b0, st: ST_IDLE,
             cnt: tcic_pkg::RST_COUNT, cap: tcic_pkg::RST_COUNT, ovf: 1'b0,
             ovf_pend: 1'b0, irq: 1'b0, tick_d: 1'b0, ack: 1'b0, dat: 32'h0};
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign channel_interrupt = s.irq;

endmodule
